// file: rtl/pcpd_core.sv
// Pin-controlled power-down control: freezes state and outputs while the
// request pin is high, blocks inputs, and keeps pin levels held.
// Assumes the far side sequences inputs, enables and clocks around the
// request edges; one clock domain, no software registers.
//
// Summary of operation
// - Enabled option: pin high requests power-down
// - Register and output values frozen while down
// - Tri-stated outputs stay tri-stated while down
// - All inputs except request blocked while down
// - Pin hold latches keep last level
// - Without option the pin is ordinary
// - Request pin array input lost; feedback kept
// - Inputs accepted within 1 us after fall
// - Valid updating outputs within 1 us
`timescale 1ns/100ps
module pcpd_core #(
  parameter int unsigned WIDTH       = pcpd_pkg::PIN_WIDTH,
  parameter int unsigned WAKE_CYCLES = pcpd_pkg::WAKE_CYCLES
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             power_down_enable,
  input  wire logic             power_down_pin_in,
  output logic                  power_down_pin_out,
  output logic                  power_down_pin_oe,
  input  wire logic [WIDTH-1:0] pin_in,
  input  wire logic [WIDTH-1:0] pin_driven,
  input  wire logic [WIDTH-1:0] user_next_out,
  input  wire logic [WIDTH-1:0] user_next_oe,
  input  wire logic [WIDTH-1:0] user_next_state,
  output logic                  pd_pin_user_out,
  input  wire logic             pd_pin_user_oe,
  output logic [WIDTH-1:0]      array_in,
  output logic                  array_pd_in,
  output logic [WIDTH-1:0]      state_q,
  output logic [WIDTH-1:0]      pin_out,
  output logic [WIDTH-1:0]      pin_oe,
  output logic                  powered_down,
  output logic                  awake
);

  // ==========================================================================
  // Mode control
  pcpd_pkg::pcpd_mode_e            mode;
  pcpd_pkg::pcpd_mode_e            next_mode;
  logic [pcpd_pkg::WAKE_CNT_WIDTH-1:0] wake_cnt;
  logic                            request;
  logic                            frozen;
  logic [WIDTH-1:0]                kept;
  logic [WIDTH-1:0]                in_hold;
  pcpd_pkg::pcpd_drive_s           drive;

  // ==========================================================================
  // Mode decode, shared by the freeze term and the status flags
  function automatic logic mode_is(
    input pcpd_pkg::pcpd_mode_e m,
    input pcpd_pkg::pcpd_mode_e want
  );
    return (m == want);
  endfunction

  // ==========================================================================
  // Freeze
  assign request = power_down_enable & power_down_pin_in;
  // Outputs and state freeze in the same cycle the request is seen, and stay
  // frozen for the edge at which it falls: pads may still be settling then,
  // so nothing is taken until the far side has had one full cycle to recover
  assign frozen  = request | mode_is(mode, pcpd_pkg::PCPD_DOWN);

  always_comb begin
    next_mode = mode;
    case (mode)
      pcpd_pkg::PCPD_RUN: begin
        if (request) begin
          next_mode = pcpd_pkg::PCPD_DOWN;
        end
      end
      pcpd_pkg::PCPD_DOWN: begin
        if (!request) begin
          next_mode = pcpd_pkg::PCPD_WAKE;
        end
      end
      pcpd_pkg::PCPD_WAKE: begin
        // A new request inside the wake window goes straight back down
        if (request) begin
          next_mode = pcpd_pkg::PCPD_DOWN;
        end else if (wake_cnt == pcpd_pkg::WAKE_CNT_WIDTH'(WAKE_CYCLES - 1)) begin
          next_mode = pcpd_pkg::PCPD_RUN;
        end
      end
      default: begin
        next_mode = pcpd_pkg::PCPD_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode <= pcpd_pkg::PCPD_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // Wake window counter; the block is already live during it, the count only
  // reports the guaranteed bound to the system
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wake_cnt <= '0;
    end else if (mode == pcpd_pkg::PCPD_WAKE && !request) begin
      wake_cnt <= wake_cnt + 1'b1;
    end else begin
      wake_cnt <= '0;
    end
  end

  // ==========================================================================
  // Pin keepers
  // The block's own enables count as drivers: a pin it drives never needs
  // holding, and its read-back follows the level it puts out
  pcpd_keeper #(
    .WIDTH (WIDTH)
  ) u_keeper (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .pad_in     (pin_in),
    .pad_driven (pin_driven),
    .ext_en     (pin_oe),
    .kept       (kept)
  );

  // ==========================================================================
  // Input blocking: the array sees the last level taken before power-down
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      in_hold <= '0;
    end else if (!frozen) begin
      in_hold <= kept;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      array_in <= '0;
    end else if (!frozen) begin
      array_in <= kept;
    end else begin
      array_in <= in_hold;
    end
  end

  // With the option on, the request pin never reaches the array; it is parked
  // low so that toggling the request cannot disturb logic that reads it
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      array_pd_in <= 1'b0;
    end else if (power_down_enable) begin
      array_pd_in <= 1'b0;
    end else begin
      array_pd_in <= power_down_pin_in;
    end
  end

  // ==========================================================================
  // State and output freeze
  // A frozen edge drops the user's next values; the user logic presents them
  // again afterwards, since it computes them from the held state
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= pcpd_pkg::STATE_RESET;
    end else if (!frozen) begin
      state_q <= user_next_state;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      drive <= '0;
    end else if (!frozen) begin
      drive.out_val <= user_next_out;
      drive.out_en  <= user_next_oe;
    end
  end

  assign pin_out = drive.out_val;
  assign pin_oe  = drive.out_en;

  // ==========================================================================
  // Request pin as an ordinary pin when the option is off; its macrocell
  // feedback stays available either way
  // Limitation: as an ordinary pin it lags the macrocell by one cycle, since
  // the pad drive is a registered copy
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      power_down_pin_out <= 1'b0;
      power_down_pin_oe  <= 1'b0;
    end else if (power_down_enable) begin
      power_down_pin_oe  <= 1'b0;
    end else begin
      power_down_pin_out <= state_q[0];
      power_down_pin_oe  <= pd_pin_user_oe;
    end
  end

  assign pd_pin_user_out = state_q[0];

  // ==========================================================================
  // Status flags
  // Registered from the next mode, so they change with the mode register
  // and carry no decode glitch out to the pins
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      powered_down <= 1'b0;
      awake        <= 1'b1;
    end else begin
      powered_down <= mode_is(next_mode, pcpd_pkg::PCPD_DOWN);
      awake        <= mode_is(next_mode, pcpd_pkg::PCPD_RUN);
    end
  end

endmodule

// file: rtl/pcpd_pkg.sv
// Shared constants and carriers for the pin-controlled power-down block.
// Assumes a single 20 MHz system clock; all pins are synchronous to it.
package pcpd_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned PIN_WIDTH = 8;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned WAKE_TIME_US  = 1;
  // Longest time: round down, at least one cycle
  localparam int unsigned WAKE_CYCLES_RAW = (WAKE_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_CYCLES     = (WAKE_CYCLES_RAW < 1) ? 1 : WAKE_CYCLES_RAW;
  localparam int unsigned WAKE_CNT_WIDTH  = 8;

  // ==========================================================================
  // Reset values
  localparam logic [PIN_WIDTH-1:0] STATE_RESET = 8'h00;

  // ==========================================================================
  // Modes
  typedef enum logic [1:0] {
    PCPD_RUN   = 2'b00,
    PCPD_DOWN  = 2'b01,
    PCPD_WAKE  = 2'b10
  } pcpd_mode_e;

  // Pin group: value and enable driven onto the pad
  typedef struct packed {
    logic [PIN_WIDTH-1:0] out_val;
    logic [PIN_WIDTH-1:0] out_en;
  } pcpd_drive_s;

endpackage

// file: rtl/pcpd_keeper.sv
// Hold latch for a group of input and bidirectional pins.
// Assumes pad levels are sampled synchronously; a pin not driven by anyone
// is flagged by the pad model via pad_driven low, whatever level it then presents.
`timescale 1ns/100ps
module pcpd_keeper #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pad_in,
  input  wire logic [WIDTH-1:0] pad_driven,
  input  wire logic [WIDTH-1:0] ext_en,
  output logic      [WIDTH-1:0] kept
);

  // ==========================================================================
  // Keeper: a driven pin updates, an undriven one keeps its last level
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      kept <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (pad_driven[i] || ext_en[i]) begin
          kept[i] <= pad_in[i];
        end
      end
    end
  end

endmodule

// file: dv/pcpd_core_asserts.sv
// Port assertions for the power-down block.
// Assumes one clock domain; bound into every pcpd_core.
`timescale 1ns/100ps
module pcpd_core_asserts #(
  parameter int unsigned WIDTH       = 8,
  parameter int unsigned WAKE_CYCLES = 20
) (
  input wire logic             clk_sys,
  input wire logic             reset_n,
  input wire logic             power_down_enable,
  input wire logic             power_down_pin_in,
  input wire logic             power_down_pin_out,
  input wire logic             power_down_pin_oe,
  input wire logic             pd_pin_user_out,
  input wire logic             pd_pin_user_oe,
  input wire logic [WIDTH-1:0] array_in,
  input wire logic             array_pd_in,
  input wire logic [WIDTH-1:0] state_q,
  input wire logic [WIDTH-1:0] pin_out,
  input wire logic [WIDTH-1:0] pin_oe,
  input wire logic [WIDTH-1:0] user_next_state,
  input wire logic             powered_down,
  input wire logic             awake
);
  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire req = power_down_enable & power_down_pin_in;
  a_state_frozen: assert property (req |=> $stable(state_q)) else $error("state moved while down");
  a_out_frozen: assert property (req |=> $stable({pin_out, pin_oe})) else $error("outputs moved while down");
  a_input_blocked: assert property (req |=> $stable(array_in)) else $error("input passed while down");
  // The edge at which the request falls is still a frozen one
  a_state_resumes: assert property (!req && !$past(req) |=> state_q == $past(user_next_state))
    else $error("state not updated");
  a_down_flag: assert property (req |=> powered_down && !awake) else $error("not powered down");
  // Upper bound with no slack at 20 wake cycles: the full 1 us budget plus the sampling cycle
  a_wake_bound: assert property (powered_down && !req |-> ##[1:21] (awake || req))
    else $error("wake took too long");
  a_pin_claimed: assert property (
    power_down_enable && $past(power_down_enable) |-> !power_down_pin_oe && !array_pd_in)
    else $error("request pin still ordinary");
  a_feedback_kept: assert property (
    power_down_enable && !req && !$past(req) |=> pd_pin_user_out == $past(user_next_state[0]))
    else $error("feedback lost");
  a_pin_ordinary: assert property (
    !power_down_enable && !$past(power_down_enable) |-> power_down_pin_out == $past(pd_pin_user_out)
      && power_down_pin_oe == $past(pd_pin_user_oe) && array_pd_in == $past(power_down_pin_in))
    else $error("pin not ordinary with option off");
endmodule
bind pcpd_core pcpd_core_asserts #(.WIDTH(WIDTH), .WAKE_CYCLES(WAKE_CYCLES)) u_chk (.*);

// file: dv/pcpd_ext_model.sv
// External logic that drives the request pin and the input pads.
// Assumes the bench gives a level go_down and the pad value to present.
`timescale 1ns/100ps
module pcpd_ext_model (
  input  wire logic       clk_sys,
  input  wire logic       go_down,
  input  wire logic [7:0] pin_val,
  output logic            power_down_pin_in,
  output logic      [7:0] pin_in,
  output logic      [7:0] pin_driven
);
  logic [1:0] settle;
  initial begin
    power_down_pin_in = 1'b0;
    pin_in = 8'h00;
    pin_driven = 8'hff;
    settle = 2'h0;
  end
  // Pads freeze at the edge of the rise and are released two cycles after it
  always @(posedge clk_sys) begin
    power_down_pin_in <= go_down;
    settle <= go_down ? {settle[0], 1'b1} : 2'h0;
    pin_driven <= settle[1] ? 8'h00 : 8'hff;
    if (!go_down && !power_down_pin_in) pin_in <= pin_val;
    else if (settle[1]) pin_in <= ~pin_in;
  end
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the power-down block.
// Assumes the external logic model and the bound checker.
`timescale 1ns/100ps
module tb_top;
  // ==========================================================================
  // Stimulus and observation
  logic        clk_sys = 1'b0, reset_n = 1'b0, en = 1'b1, go_down = 1'b0, pd_user_oe = 1'b0;
  logic [7:0]  pin_val = 8'h00, nxt_out = 8'h00, nxt_oe = 8'h00, nxt_state = 8'h00;
  logic        pd_pin, pd_user_out, powered_down, awake, pd_arr, prev_req = 1'b0;
  logic [7:0]  pin_in, pin_driven, array_in, state_q, pin_out, pin_oe;
  logic [23:0] exp_word = 24'h000000;
  logic [23:0] exp_q[$];
  int          error_cnt = 0, check_count = 0;
  always #25 clk_sys = ~clk_sys;
  // Request seen at the previous edge: the block stays frozen one edge longer
  always @(posedge clk_sys) prev_req <= en && pd_pin;
  pcpd_core #(.WAKE_CYCLES(2)) u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .power_down_enable(en),
    .power_down_pin_in(pd_pin), .power_down_pin_out(), .power_down_pin_oe(), .pin_in(pin_in),
    .pin_driven(pin_driven), .user_next_out(nxt_out), .user_next_oe(nxt_oe), .user_next_state(nxt_state),
    .pd_pin_user_out(pd_user_out), .pd_pin_user_oe(pd_user_oe), .array_in(array_in), .array_pd_in(pd_arr),
    .state_q(state_q), .pin_out(pin_out), .pin_oe(pin_oe), .powered_down(powered_down), .awake(awake));
  pcpd_ext_model u_ext (.clk_sys(clk_sys), .go_down(go_down), .pin_val(pin_val), .power_down_pin_in(pd_pin),
    .pin_in(pin_in), .pin_driven(pin_driven));
  // ==========================================================================
  // Tasks
  task automatic chk_word(input logic [23:0] e, input logic [23:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t held word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_sig(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t level %h expected %h", $time, g, e);
    end
  endtask
  // Old request level is read at the edge, so the note matches what the edge does
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      if (!(en && pd_pin) && !prev_req) exp_word = {nxt_state, nxt_out, nxt_oe};
      exp_q.push_back(exp_word);
      {nxt_state, nxt_out, nxt_oe, pd_user_oe} <= 25'($urandom);
    end
  endtask
  task automatic episode(input logic enable);
    logic [7:0] held;
    int i;
    step(1);
    en <= enable;
    pin_val <= 8'($urandom);
    step(3);
    held = pin_val;
    go_down <= 1'b1;
    pin_val <= ~pin_val;
    step(8);
    go_down <= 1'b0;
    @(negedge clk_sys);
    chk_sig({7'h00, enable}, {7'h00, powered_down});
    chk_sig({7'h00, ~enable}, {7'h00, pd_arr});
    if (enable) chk_sig(held, array_in);
    for (i = 0; i < 30 && awake !== 1'b1; i++) step(1);
    @(negedge clk_sys);
    chk_sig(8'h01, {7'h00, awake});
    step(5);
    @(negedge clk_sys);
    chk_sig(~held, array_in);
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================================
  // Checking, sequence and watchdog
  always @(negedge clk_sys) if (exp_q.size() > 0) chk_word(exp_q.pop_front(), {state_q, pin_out, pin_oe});
  initial begin
    void'($urandom(56561));
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    episode(1'b1);
    episode(1'b0);
    episode(1'b1);
    end_of_test();
  end
  // Three episodes take under 150 cycles; 400 leaves ample margin
  initial begin
    #20000;
    error_cnt++;
    end_of_test();
  end
endmodule
